// *** include/igd_pkg.sv ***
// constants, register map and types of the gate driver control block
package igd_pkg;
  localparam int CLK_NS = 10;
  localparam int DGL_NS = 40;
  localparam int DGL_CYC = (DGL_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSTFIL_NS = 1000;
  localparam int RSTFIL_CYC = (RSTFIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int MUTE_NS = 10000;
  localparam int MUTE_CYC = (MUTE_NS + CLK_NS - 1) / CLK_NS;
  localparam int PWM_PERIOD_NS = 2500;
  localparam int PWM_CYC = PWM_PERIOD_NS / CLK_NS;
  localparam int DUTY_HI_PCT = 88;
  localparam int DUTY_LO_PCT = 10;
  localparam int DUTY_HI_CYC = PWM_CYC * DUTY_HI_PCT / 100;
  localparam int DUTY_LO_CYC = PWM_CYC * DUTY_LO_PCT / 100;
  localparam int SENSE_MAX = 255;
  localparam int CNT_W = 11;
  localparam int NPIN = 5;
  localparam int PIN_NONINV = 0;
  localparam int PIN_INV = 1;
  localparam int PIN_RSTEN = 2;
  localparam int PIN_OC = 3;
  localparam int PIN_UNDERVOLTAGE_LOCKOUT = 4;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_SENSE = 8'h08;
  localparam int CTRL_GATE_ALLOW = 0;
  localparam int CTRL_PWM_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam int ST_FAULT = 0;
  localparam int ST_UNDERVOLTAGE_LOCKOUT = 1;
  localparam int ST_DRV_EN = 2;
  localparam int ST_GATE_ON = 3;
  localparam int ST_MUTING = 4;
  localparam int ST_ARMED = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {FLT_RUN, FLT_MUTE, FLT_WAIT, FLT_ARMED} igd_fault_t;
endpackage

// *** include/igd_filt_if.sv ***
// pin-to-filter carrier between the top and one deglitch filter
`timescale 1ns/1ps
interface igd_filt_if;
  logic raw;
  logic clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

// *** rtl/igd_deglitch.sv ***
// three-flop synchroniser followed by a minimum-width pulse filter
`timescale 1ns/1ps
module igd_deglitch #(
  parameter int unsigned CYC = 4,
  parameter logic INIT = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  igd_filt_if.filt pin
);
  import igd_pkg::*;
  logic s1, s2, s3;
  logic [2:0] cnt;
  logic agree;

  assign agree = (s2 == s3);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else if (ce) begin
      s1 <= pin.raw;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // a level must hold CYC cycles before it is passed on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 3'h0;
      pin.clean <= INIT;
    end else if (ce) begin
      if (agree && s3 != pin.clean) begin
        if (cnt == 3'(CYC - 1)) begin
          pin.clean <= s3;
          cnt <= 3'h0;
        end else begin
          cnt <= cnt + 3'h1;
        end
      end else begin
        cnt <= 3'h0;
      end
    end
  end
endmodule

// *** rtl/igd_ctrl.sv ***
// gate driver control: interlock, fault latch, undervoltage, enable, sense pwm
// Operation
// - an overcurrent seen while the gate is on turns it off and pulls fault_flag_n low.
// - the fault stays latched with the gate off and the flag low until a reset on reset_enable_input.
// - while a fault is latched the gate is turned off by the soft, reduced-strength pull-down.
// - while undervoltage_lockout is active the gate is held low and power good is dropped.
// - leaving undervoltage_lockout resumes operation and restores power good with no reset.
// - noninv_input, inv_input and reset_enable_input each pass a filter that drops pulses under 40 ns.
// - with noninv_input and inv_input both high the gate is forced low.
// - reset_enable_input enables or disables the gate output apart from clearing faults.
// - sense_pwm_output carries a pwm whose duty encodes the sense_input value.
// - for fault_mute_time after a fault the reset pin is ignored.
// - after the mute, a low longer than reset_filter_time then a rising edge clears the fault.
// - a low on reset_enable_input longer than reset_filter_time disables the driver.
// - sense duty falls linearly from 88% to 10% as the sense value rises; open input gives 10%.
`timescale 1ns/1ps
module igd_ctrl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic noninv_input,
  input wire logic inv_input,
  input wire logic reset_enable_input,
  input wire logic overcurrent_detect,
  input wire logic undervoltage_lockout,
  input wire logic [7:0] sense_input,
  output logic gate_pullup_out,
  output logic gate_pulldown_out,
  output logic gate_softoff_out,
  output logic fault_flag_n_o,
  output logic fault_flag_n_oe,
  output logic power_good_flag_o,
  output logic power_good_flag_oe,
  output logic sense_pwm_output
);
  import igd_pkg::*;

  logic [NPIN-1:0] pins, cln;
  logic in_p, in_n, rst_c, oc_c, undervoltage_lockout_c;
  logic [1:0] ctrl;
  logic aw_got, w_got, do_wr;
  logic [7:0] aw_addr;
  logic [1:0] wr_ctrl;
  logic [CNT_W-1:0] low_cnt, flt_cnt;
  logic drv_en, rst_d, rst_rise, gate_on, fault, fault_set;
  igd_fault_t flt_st;
  logic [7:0] pwm_cnt, duty, sense_q;

  assign pins = {undervoltage_lockout, overcurrent_detect, reset_enable_input, inv_input, noninv_input};

  // oc and undervoltage_lockout are only synchronised; the control pins also drop short pulses
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    igd_filt_if fif();
    assign fif.raw = pins[i];
    assign cln[i] = fif.clean;
    igd_deglitch #(
      .CYC((i == PIN_OC || i == PIN_UNDERVOLTAGE_LOCKOUT) ? 1 : DGL_CYC),
      .INIT(1'b0)
    ) u_filt (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .pin(fif.filt)
    );
  end

  assign in_p = cln[PIN_NONINV];
  assign in_n = cln[PIN_INV];
  assign rst_c = cln[PIN_RSTEN];
  assign oc_c = cln[PIN_OC];
  assign undervoltage_lockout_c = cln[PIN_UNDERVOLTAGE_LOCKOUT];

  function automatic logic [7:0] duty_of(input logic [7:0] s);
    logic [15:0] prod;
    prod = 16'(s) * 16'(DUTY_HI_CYC - DUTY_LO_CYC);
    duty_of = 8'(DUTY_HI_CYC) - 8'((prod + 16'(SENSE_MAX / 2)) / 16'(SENSE_MAX));
  endfunction

  function automatic logic [31:0] rd_word(input logic [7:0] a);
    rd_word = 32'h0;
    unique case (a)
      ADDR_CTRL: rd_word[1:0] = ctrl;
      ADDR_STATUS: begin
        rd_word[ST_FAULT] = fault;
        rd_word[ST_UNDERVOLTAGE_LOCKOUT] = undervoltage_lockout_c;
        rd_word[ST_DRV_EN] = drv_en;
        rd_word[ST_GATE_ON] = gate_pullup_out;
        rd_word[ST_MUTING] = (flt_st == FLT_MUTE);
        rd_word[ST_ARMED] = (flt_st == FLT_ARMED);
      end
      ADDR_SENSE: rd_word[15:0] = {sense_q, duty};
      default: rd_word = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == ADDR_CTRL) || (a == ADDR_STATUS) || (a == ADDR_SENSE);
  endfunction

  // write side: address and data accepted in either order, answer after both
  assign s_axi_awready = ce && !aw_got && !s_axi_bvalid;
  assign s_axi_wready = ce && !w_got && !s_axi_bvalid;
  assign do_wr = ce && aw_got && w_got && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got <= 1'b0;
      aw_addr <= 8'h0;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got <= 1'b0;
      wr_ctrl <= 2'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wr_ctrl <= s_axi_wstrb[0] ? s_axi_wdata[1:0] : ctrl;
      end else if (do_wr) begin
        w_got <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (do_wr && aw_addr == ADDR_CTRL) begin
      ctrl <= wr_ctrl;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (ce) begin
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read side: data registered on the address handshake
  assign s_axi_arready = ce && !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word(s_axi_araddr);
        s_axi_rresp <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // enable follows the pin at once upward, but only a long low disables
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= '0;
      drv_en <= 1'b0;
      rst_d <= 1'b0;
    end else if (ce) begin
      rst_d <= rst_c;
      if (rst_c) begin
        low_cnt <= '0;
        drv_en <= 1'b1;
      end else if (low_cnt == CNT_W'(RSTFIL_CYC - 1)) begin
        drv_en <= 1'b0;
      end else begin
        low_cnt <= low_cnt + CNT_W'(1);
      end
    end
  end

  assign rst_rise = rst_c && !rst_d;
  assign fault = (flt_st != FLT_RUN);
  // desaturation sensing only works while the switch is on
  assign fault_set = oc_c && gate_pullup_out;
  assign gate_on = in_p && !in_n && drv_en && !undervoltage_lockout_c && !fault && ctrl[CTRL_GATE_ALLOW];

  // fault latch: mute, then a long low, then a rising edge clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flt_st <= FLT_RUN;
      flt_cnt <= '0;
    end else if (ce) begin
      if (fault_set) begin
        flt_st <= FLT_MUTE;
        flt_cnt <= '0;
      end else begin
        unique case (flt_st)
          FLT_RUN: flt_cnt <= '0;
          FLT_MUTE: begin
            if (flt_cnt == CNT_W'(MUTE_CYC - 1)) begin
              flt_st <= FLT_WAIT;
              flt_cnt <= '0;
            end else begin
              flt_cnt <= flt_cnt + CNT_W'(1);
            end
          end
          FLT_WAIT: begin
            if (rst_c) begin
              flt_cnt <= '0;
            end else if (flt_cnt == CNT_W'(RSTFIL_CYC - 1)) begin
              flt_st <= FLT_ARMED;
            end else begin
              flt_cnt <= flt_cnt + CNT_W'(1);
            end
          end
          FLT_ARMED: begin
            if (rst_rise) begin
              flt_st <= FLT_RUN;
            end
          end
        endcase
      end
    end
  end

  // outputs: soft off replaces the full pull-down while latched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_pullup_out <= 1'b0;
      gate_pulldown_out <= 1'b1;
      gate_softoff_out <= 1'b0;
    end else if (ce) begin
      gate_pullup_out <= gate_on && !fault_set;
      gate_pulldown_out <= !gate_on && !fault && !fault_set;
      gate_softoff_out <= fault || fault_set;
    end
  end

  // open-drain flags: enable high means the pin is pulled low
  assign fault_flag_n_o = 1'b0;
  assign fault_flag_n_oe = fault;
  assign power_good_flag_o = 1'b0;
  assign power_good_flag_oe = undervoltage_lockout_c;

  // sense pwm: duty sampled once a period so it never changes mid-cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt <= 8'h0;
      duty <= 8'(DUTY_LO_CYC);
      sense_q <= 8'h0;
      sense_pwm_output <= 1'b0;
    end else if (ce) begin
      if (pwm_cnt == 8'(PWM_CYC - 1)) begin
        pwm_cnt <= 8'h0;
        sense_q <= sense_input;
        duty <= duty_of(sense_input);
      end else begin
        pwm_cnt <= pwm_cnt + 8'h1;
      end
      sense_pwm_output <= ctrl[CTRL_PWM_EN] && (pwm_cnt < duty);
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_arm_rise;
    ce && flt_st == FLT_ARMED && rst_rise && !fault_set;
  endsequence
  sequence s_detect;
    ce && fault_set;
  endsequence

  AST_INTERLOCK: assert property (ce && in_p && in_n |=> !gate_pullup_out)
    else $error("gate high with both inputs high");
  AST_FAULT_OFF: assert property (s_detect |=> !gate_pullup_out && gate_softoff_out && fault_flag_n_oe)
    else $error("fault did not shut the gate softly");
  AST_FAULT_HOLD: assert property (ce && fault && flt_st != FLT_ARMED |=> fault)
    else $error("fault cleared without reset sequence");
  AST_SOFT_OFF: assert property (fault |-> !gate_pulldown_out ##1 1)
    else $error("full pull-down during fault");
  AST_UNDERVOLTAGE_LOCKOUT_LOW: assert property (ce && undervoltage_lockout_c |-> power_good_flag_oe ##1 !gate_pullup_out)
    else $error("gate high in undervoltage");
  AST_UNDERVOLTAGE_LOCKOUT_RESUME: assert property ($fell(undervoltage_lockout_c) |-> !power_good_flag_oe)
    else $error("power good not restored");
  AST_MUTE: assert property (s_detect |=> fault [*8])
    else $error("fault cleared during mute");
  AST_CLEAR: assert property (s_arm_rise |=> !fault_flag_n_oe)
    else $error("armed fault not cleared on rising edge");
  AST_DISABLE: assert property (ce && !rst_c && low_cnt == CNT_W'(RSTFIL_CYC - 1) |=> !drv_en ##1 !gate_pullup_out)
    else $error("driver not disabled after long low");
  AST_PWM_HIGH: assert property (ce && ctrl[CTRL_PWM_EN] && pwm_cnt == 8'h0 |=> sense_pwm_output)
    else $error("sense pwm not high at period start");
  AST_PWM_LOW: assert property (ce && pwm_cnt == 8'(PWM_CYC - 1) |=> !sense_pwm_output)
    else $error("sense pwm high at period end");
endmodule

// *** dv/igd_host_model.sv ***
// host controller model: drives pwm and enable pins, reads the open-drain flags
`timescale 1ns/1ps
module igd_host_model (
  input wire logic aclk,
  input wire logic slow,
  input wire logic [2:0] cmd,
  input wire logic fault_flag_n_o,
  input wire logic fault_flag_n_oe,
  input wire logic power_good_flag_o,
  input wire logic power_good_flag_oe,
  output logic noninv_input,
  output logic inv_input,
  output logic reset_enable_input,
  output logic fault_seen_n,
  output logic power_good_seen
);
  logic [2:0] lag = 3'h0;
  logic [2:0] pins = 3'h0;
  // own pwm on noninv, companion pwm on inv, inv held at ground when unused
  // every pin always driven, never left floating
  // slow mode answers one cycle late
  always_ff @(posedge aclk) begin
    lag <= cmd;
    pins <= slow ? lag : cmd;
  end
  assign {reset_enable_input, inv_input, noninv_input} = pins;
  // pull-ups on both flag lines
  assign fault_seen_n = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  assign power_good_seen = power_good_flag_oe ? power_good_flag_o : 1'b1;
endmodule

// *** dv/igd_ctrl_tb.sv ***
// self-checking bench of the gate driver control block
`timescale 1ns/1ps
module igd_ctrl_tb;
  import igd_pkg::*;
  typedef struct packed {logic [2:0] cmd; logic [7:0] hold; logic exp;} igd_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, sense_input = 8'hff;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic overcurrent_detect = 1'b0, undervoltage_lockout = 1'b0, slow = 1'b0;
  logic [2:0] cmd = 3'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic noninv_input, inv_input, reset_enable_input, fault_seen_n, power_good_seen;
  logic gate_pullup_out, gate_pulldown_out, gate_softoff_out, sense_pwm_output;
  logic fault_flag_n_o, fault_flag_n_oe, power_good_flag_o, power_good_flag_oe;
  int n_mismatch = 0;
  int checks_done = 0;
  int cycles = 0;
  // en, inv, noninv; the two en-low rows add up past the reset filter time
  igd_row_t rows [8] = '{'{3'h5, 8'h0e, 1'b1}, '{3'h7, 8'h0e, 1'b0}, '{3'h6, 8'h0e, 1'b0},
    '{3'h4, 8'h0e, 1'b0}, '{3'h5, 8'h0e, 1'b1}, '{3'h1, 8'h32, 1'b1}, '{3'h1, 8'h50, 1'b0},
    '{3'h5, 8'h0e, 1'b1}};

  igd_ctrl igd_ctrl_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .noninv_input, .inv_input, .reset_enable_input,
    .overcurrent_detect, .undervoltage_lockout, .sense_input, .gate_pullup_out,
    .gate_pulldown_out, .gate_softoff_out, .fault_flag_n_o, .fault_flag_n_oe,
    .power_good_flag_o, .power_good_flag_oe, .sense_pwm_output);
  igd_host_model igd_host_model_i (.aclk, .slow, .cmd, .fault_flag_n_o, .fault_flag_n_oe,
    .power_good_flag_o, .power_good_flag_oe, .noninv_input, .inv_input,
    .reset_enable_input, .fault_seen_n, .power_good_seen);

  always #5 aclk = ~aclk;

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // generous ceiling, the run needs about 3100 cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 12000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        chk("bresp", s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask

  // a 30 ns pulse must not reach the gate
  task automatic glitch(input logic [2:0] base, input logic [2:0] pulse, input logic exp);
    logic bad;
    bad = 1'b0;
    cmd <= pulse;
    cyc(3);
    cmd <= base;
    repeat (14) begin
      @(posedge aclk);
      bad |= (gate_pullup_out !== exp);
    end
    chk("glitch", bad, 1'b0);
  endtask

  // any full period window holds exactly the duty count
  task automatic duty(input logic [7:0] s, input int exp);
    int hi;
    hi = 0;
    sense_input <= s;
    cyc(2 * PWM_CYC);
    repeat (PWM_CYC) begin
      @(posedge aclk);
      hi += int'(sense_pwm_output === 1'b1);
    end
    chk("duty", hi, exp);
  endtask

  initial begin
    cyc(5);
    aresetn <= 1'b1;
    cyc(1);
    chk("pullup", gate_pullup_out, 1'b0);
    chk("pulldown", gate_pulldown_out, 1'b1);
    axr(ADDR_CTRL, 32'h3, RESP_OKAY);
    axr(8'h0c, 32'h0, RESP_SLVERR);
    axw(8'h10, 32'h0, RESP_SLVERR);
    foreach (rows[i]) begin
      cmd <= rows[i].cmd;
      cyc(rows[i].hold);
      chk("pullup", gate_pullup_out, rows[i].exp);
      chk("pulldown", gate_pulldown_out, !rows[i].exp);
    end
    axw(ADDR_CTRL, 32'h2, RESP_OKAY);
    cyc(3);
    chk("pullup", gate_pullup_out, 1'b0);
    axw(ADDR_CTRL, 32'h3, RESP_OKAY);
    cyc(3);
    chk("pullup", gate_pullup_out, 1'b1);
    glitch(3'h5, 3'h7, 1'b1);
    cmd <= 3'h4;
    cyc(14);
    glitch(3'h4, 3'h5, 1'b0);
    cmd <= 3'h5;
    cyc(14);
    undervoltage_lockout <= 1'b1;
    cyc(8);
    chk("pullup", gate_pullup_out, 1'b0);
    chk("power good", power_good_seen, 1'b0);
    undervoltage_lockout <= 1'b0;
    cyc(8);
    chk("pullup", gate_pullup_out, 1'b1);
    chk("power good", power_good_seen, 1'b1);
    // slow host for the fault sequence
    slow <= 1'b1;
    overcurrent_detect <= 1'b1;
    cyc(3);
    overcurrent_detect <= 1'b0;
    cyc(5);
    chk("pullup", gate_pullup_out, 1'b0);
    chk("fault", fault_seen_n, 1'b0);
    chk("softoff", gate_softoff_out, 1'b1);
    axr(ADDR_STATUS, (32'h1 << ST_FAULT) | (32'h1 << ST_DRV_EN) | (32'h1 << ST_MUTING), RESP_OKAY);
    // full reset pulse inside the mute window is ignored
    cmd <= 3'h1;
    cyc(150);
    cmd <= 3'h5;
    cyc(20);
    chk("fault", fault_seen_n, 1'b0);
    chk("pullup", gate_pullup_out, 1'b0);
    cyc(900);
    cmd <= 3'h1;
    cyc(120);
    chk("fault", fault_seen_n, 1'b0);
    cmd <= 3'h5;
    cyc(16);
    chk("fault", fault_seen_n, 1'b1);
    chk("softoff", gate_softoff_out, 1'b0);
    chk("pullup", gate_pullup_out, 1'b1);
    // clock enable low: state frozen, a pin low that ends before ce returns is never seen
    ce <= 1'b0;
    cmd <= 3'h4;
    cyc(20);
    chk("frozen pullup", gate_pullup_out, 1'b1);
    chk("arready", s_axi_arready, 1'b0);
    cmd <= 3'h5;
    cyc(4);
    ce <= 1'b1;
    cyc(12);
    chk("pullup", gate_pullup_out, 1'b1);
    duty(8'h00, DUTY_HI_CYC);
    duty(8'hff, DUTY_LO_CYC);
    axr(ADDR_SENSE, {16'h0, 8'hff, 8'(DUTY_LO_CYC)}, RESP_OKAY);
    // mid-run reset: driver off until the enable pin is seen again
    aresetn <= 1'b0;
    cyc(2);
    chk("pullup", gate_pullup_out, 1'b0);
    chk("pulldown", gate_pulldown_out, 1'b1);
    chk("pwm", sense_pwm_output, 1'b0);
    aresetn <= 1'b1;
    cyc(2);
    chk("pullup", gate_pullup_out, 1'b0);
    cyc(12);
    chk("pullup", gate_pullup_out, 1'b1);
    results();
  end
endmodule
